// ---- rtl/pgc_regs.sv ----
// Gain and global configuration register bank, with the chop settle
// timer and current-detect trigger combining.
// Assumes a synchronous plain register port and datapath strobes.
// Contract
// - Channel 7 gain code lives in upper gain word bits 14:12, gain 2^n.
// - Channel 6 gain code lives in upper gain word bits 10:8, gain 2^n.
// - Channel 5 gain code lives in upper gain word bits 6:4, gain 2^n.
// - Channel 4 gain code in bits 2:0; all gain fields reset to unity.
// - Config bits 12:9 pick chop settle of 2^(k+1) modulator clocks.
// - Config bit 8 enables global chop; resets to disabled.
// - Config bit 7 clear: any channel triggers; set: all channels needed.
// - Config word at address 06h resets to 0600h.
// - Config bit 0 enables current-detect mode; resets to disabled.
//
// Added by the designer: strobed register access.
module pgc_regs
  import pgc_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic [ADDR_W-1:0]         addr_i,
  input  wire logic [DATA_W-1:0]         wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  input  wire logic                      mod_tick_i,
  input  wire logic                      chop_phase_i,
  input  wire logic [NUM_UPPER-1:0]      conv_start_i,
  input  wire logic [NUM_CH-1:0]         ch_qualify_i,
  output logic      [DATA_W-1:0]         rdata_o,
  output logic [NUM_UPPER*GAIN_W-1:0]    active_gain_o,
  output logic                           chop_enable_o,
  output logic                           chop_settled_o,
  output logic                           current_detect_enable_o,
  output logic                           detect_trigger_o
);
  // Settle timer: idle while chop is off, counts ticks, then measures
  typedef enum logic [1:0]
  {
    PGC_IDLE   = 2'b00,
    PGC_SETTLE = 2'b01,
    PGC_MEAS   = 2'b10
  } pgc_state_e;

  logic [DATA_W-1:0]       upper_channel_gain_word;
  logic [DATA_W-1:0]       global_config_word;
  logic [NUM_UPPER*GAIN_W-1:0] active_gain;
  logic [DLY_CNT_W-1:0]    settle_cnt;
  logic [DLY_CNT_W-1:0]    next_settle_cnt;
  pgc_state_e              state;
  pgc_state_e              next_state;
  logic                    chop_phase_q;

  function automatic logic [DATA_W-1:0] masked(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W-1:0] mask
  );
    masked = (new_v & mask) | (old_v & ~mask);
  endfunction : masked

  // Wait is 2^(k+1) ticks; the shift is one bit wider than the code so
  // the top code reaches 2^16 instead of wrapping to a single tick.
  function automatic logic [DLY_CNT_W-1:0] settle_len(
    input logic [DLY_CODE_W-1:0] code
  );
    logic [DLY_CODE_W:0] shift;
    shift = {1'b0, code} + {{DLY_CODE_W{1'b0}}, 1'b1};
    settle_len = DLY_ONE << shift;
  endfunction : settle_len

  wire hit_gain = (addr_i == UPPER_GAIN_ADDR);
  wire hit_cfg  = (addr_i == GLOBAL_CFG_ADDR);
  wire wr_gain  = wr_i && hit_gain;
  wire wr_cfg   = wr_i && hit_cfg;
  wire [DATA_W-1:0] rd_mux = hit_gain ? upper_channel_gain_word :
                             hit_cfg  ? global_config_word : UNMAPPED_READ;
  wire [DATA_W-1:0] gain_wr_value = wdata_i & UPPER_GAIN_WMASK;

  // Reserved gain bits are held at zero even if the host slips.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      upper_channel_gain_word <= UPPER_GAIN_RESET;
    else if (wr_gain)
      upper_channel_gain_word <= gain_wr_value;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      global_config_word <= GLOBAL_CFG_RESET;
    else if (wr_cfg)
      global_config_word <= masked(global_config_word, wdata_i,
                                   GLOBAL_CFG_WMASK);
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= UNMAPPED_READ;
    else if (rd_i)
      rdata_o <= rd_mux;
    else
      rdata_o <= UNMAPPED_READ;
  end

  // Channel i+4 field at bits 4*i+2 : 4*i
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UPPER; gi++)
    begin : g_gain
      pgc_gain_latch u_latch (
        .core_clk_i    (core_clk_i),
        .nrst_i        (nrst_i),
        .conv_start_i  (conv_start_i[gi]),
        .reg_code_i    (upper_channel_gain_word[gi*GAIN_STRIDE+GAIN_LO +:
                                                GAIN_W]),
        .active_code_o (active_gain[gi*GAIN_W +: GAIN_W])
      );
    end
  endgenerate

  wire chop_en  = global_config_word[CHOP_EN_BIT];
  wire current_detect_enable    = global_config_word[CURRENT_DETECT_ENABLE_BIT];
  wire all_sel  = global_config_word[ALLCH_BIT];
  wire [DLY_CODE_W-1:0] dly_code =
    global_config_word[CHOP_DLY_HI:CHOP_DLY_LO];
  wire [DLY_CNT_W-1:0] dly_len = settle_len(dly_code);
  wire phase_edge = chop_phase_i != chop_phase_q;
  wire trig = all_sel ? (&ch_qualify_i) : (|ch_qualify_i);
  // A phase flip mid-settle restarts the wait rather than counting on
  wire settle_step = mod_tick_i && !phase_edge;
  wire settle_done = settle_step && (settle_cnt == DLY_ONE);

  always_comb
  begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    case (state)
      PGC_IDLE:
      begin
        // Enabling chop starts a fresh settle
        if (chop_en)
        begin
          next_state = PGC_SETTLE;
          next_settle_cnt = dly_len;
        end
      end
      PGC_SETTLE:
      begin
        if (phase_edge)
        begin
          next_settle_cnt = dly_len;
        end
        else if (settle_step)
        begin
          next_settle_cnt = settle_cnt - DLY_ONE;
        end
        if (settle_done)
        begin
          next_state = PGC_MEAS;
        end
      end
      PGC_MEAS:
      begin
        if (phase_edge)
        begin
          next_state = PGC_SETTLE;
          next_settle_cnt = dly_len;
        end
      end
      default:
      begin
        next_state = PGC_IDLE;
        next_settle_cnt = DLY_ZERO;
      end
    endcase
    if (!chop_en)
    begin
      next_state = PGC_IDLE;
      next_settle_cnt = DLY_ZERO;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state        <= PGC_IDLE;
      settle_cnt   <= DLY_ZERO;
      chop_phase_q <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      settle_cnt   <= next_settle_cnt;
      chop_phase_q <= chop_phase_i;
    end
  end

  // Outputs registered so the datapath sees clean levels
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      active_gain_o           <= '0;
      chop_enable_o           <= 1'b0;
      chop_settled_o          <= 1'b0;
      current_detect_enable_o <= 1'b0;
      detect_trigger_o        <= 1'b0;
    end
    else
    begin
      active_gain_o           <= active_gain;
      chop_enable_o           <= chop_en;
      chop_settled_o          <= (next_state == PGC_MEAS);
      current_detect_enable_o <= current_detect_enable;
      detect_trigger_o        <= current_detect_enable && trig;
    end
  end
endmodule : pgc_regs

// ---- rtl/pgc_pkg.sv ----
// Package: register offsets, field layouts and reset values for the
// gain and global configuration register bank.
// Assumes a single 10 MHz core clock domain.
package pgc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned GAIN_W = 3;
  localparam int unsigned NUM_UPPER = 4;
  localparam int unsigned FIRST_UPPER = 4;
  localparam int unsigned GAIN_STRIDE = 4;
  localparam int unsigned GAIN_LO = 0;

  localparam logic [ADDR_W-1:0] UPPER_GAIN_ADDR = 8'h05;
  localparam logic [ADDR_W-1:0] GLOBAL_CFG_ADDR = 8'h06;

  localparam logic [DATA_W-1:0] UPPER_GAIN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] GLOBAL_CFG_RESET = 16'h0600;
  localparam logic [DATA_W-1:0] UPPER_GAIN_WMASK = 16'h7777;
  localparam logic [DATA_W-1:0] GLOBAL_CFG_WMASK = 16'hffff;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

  localparam int unsigned CHOP_DLY_HI = 12;
  localparam int unsigned CHOP_DLY_LO = 9;
  localparam int unsigned CHOP_EN_BIT = 8;
  localparam int unsigned ALLCH_BIT = 7;
  localparam int unsigned CURRENT_DETECT_ENABLE_BIT = 0;
  localparam int unsigned DLY_CODE_W = 4;
  localparam int unsigned DLY_CNT_W = 17;
  localparam int unsigned NUM_CH = 8;

  localparam logic [DLY_CNT_W-1:0] DLY_ONE = 17'h00001;
  localparam logic [DLY_CNT_W-1:0] DLY_ZERO = 17'h00000;
endpackage : pgc_pkg

// ---- rtl/pgc_gain_latch.sv ----
// One channel's gain code, taken from the register only at conversion
// start so a conversion already running keeps its gain.
// Assumes conversion start is a one-cycle pulse from the datapath.
module pgc_gain_latch
  import pgc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              conv_start_i,
  input  wire logic [GAIN_W-1:0] reg_code_i,
  output logic      [GAIN_W-1:0] active_code_o
);
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      active_code_o <= UPPER_GAIN_RESET[GAIN_W-1:0];
    else if (conv_start_i)
      active_code_o <= reg_code_i;
  end
endmodule : pgc_gain_latch

// ---- tb/pgc_regs_sva.sv ----
// Checker: port-level properties of the gain and config bank.
// Assumes one clock domain; bound to pgc_regs below.
module pgc_regs_sva
  import pgc_pkg::*;
(
  input wire logic                        core_clk_i,
  input wire logic                        nrst_i,
  input wire logic [ADDR_W-1:0]           addr_i,
  input wire logic [DATA_W-1:0]           wdata_i,
  input wire logic                        wr_i,
  input wire logic                        rd_i,
  input wire logic                        chop_phase_i,
  input wire logic [NUM_UPPER-1:0]        conv_start_i,
  input wire logic [NUM_CH-1:0]           ch_qualify_i,
  input wire logic [DATA_W-1:0]           rdata_o,
  input wire logic [NUM_UPPER*GAIN_W-1:0] active_gain_o,
  input wire logic                        chop_enable_o,
  input wire logic                        chop_settled_o,
  input wire logic                        current_detect_enable_o,
  input wire logic                        detect_trigger_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire cfg_wr = wr_i && addr_i == GLOBAL_CFG_ADDR;
  wire unmapped = addr_i != UPPER_GAIN_ADDR && addr_i != GLOBAL_CFG_ADDR;
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not idle");
  a_unmapped_read: assert property (rd_i && unmapped |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_chop_follow: assert property (
    cfg_wr ##1 !cfg_wr |=> chop_enable_o == $past(wdata_i[8], 2))
    else $error("chop enable mismatch");
  a_detect_follow: assert property (
    cfg_wr ##1 !cfg_wr |=> current_detect_enable_o == $past(wdata_i[0], 2))
    else $error("detect enable mismatch");
  a_trig_all: assert property (
    current_detect_enable_o && $past(ch_qualify_i) == 8'hff |-> detect_trigger_o)
    else $error("trigger missing");
  a_trig_none: assert property (
    $past(ch_qualify_i) == 8'h00 |-> !detect_trigger_o)
    else $error("trigger without cause");
  a_gain_hold: assert property (
    conv_start_i == 4'h0 |-> ##2 $stable(active_gain_o))
    else $error("gain changed without start");
  a_chop_off: assert property (
    !chop_enable_o ##1 !chop_enable_o |-> !chop_settled_o)
    else $error("settled while chop off");
  a_phase_restart: assert property (
    chop_phase_i != $past(chop_phase_i) |-> ##2 !chop_settled_o)
    else $error("settle not restarted");
endmodule : pgc_regs_sva

bind pgc_regs pgc_regs_sva u_sva (.*);

// ---- tb/pgc_regs_tb.sv ----
// Testbench: drives register port and datapath strobes of pgc_regs.
// Assumes the checker is bound from its own file.
module pgc_regs_tb import pgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, tick = 0, ph = 0;
  logic [7:0]  addr = 0, q = 0;
  logic [15:0] wd = 0, rdata;
  logic [3:0]  cs = 0;
  logic [11:0] gain;
  logic        ce, cst, cde, trig;
  int          mismatches = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  pgc_regs u_pgc_regs (.core_clk_i(clk), .nrst_i(rst_n), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .mod_tick_i(tick),
    .chop_phase_i(ph), .conv_start_i(cs), .ch_qualify_i(q),
    .rdata_o(rdata), .active_gain_o(gain), .chop_enable_o(ce),
    .chop_settled_o(cst), .current_detect_enable_o(cde),
    .detect_trigger_o(trig));
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_reg
  // One tick every other cycle, as the modulator would
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : ticks
  task automatic t_gain;
    logic [2:0] c;
    rd_reg(UPPER_GAIN_ADDR, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      wr_reg(8'h05, {1'b0, c, 1'b0, ~c, 1'b0, c, 1'b0, ~c});
      rd_reg(8'h05, {1'b0, c, 1'b0, ~c, 1'b0, c, 1'b0, ~c});
      @(posedge clk);
      cs <= 4'hf;
      @(posedge clk);
      cs <= 4'h0;
      repeat (3) @(posedge clk);
      #1 chk({4'h0, gain}, {4'h0, c, ~c, c, ~c});
    end
    wr_reg(8'h05, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk({4'h0, gain}, 16'h0e38);
    $display("gain test done");
  endtask : t_gain
  task automatic t_cfg;
    rd_reg(GLOBAL_CFG_ADDR, 16'h0600);
    wr_reg(8'h06, 16'h0781);
    rd_reg(8'h06, 16'h0781);
    chk(cde, 1'b1);
    @(posedge clk);
    q <= 8'h7f;
    repeat (3) @(posedge clk);
    #1 chk(trig, 1'b0);
    wr_reg(8'h06, 16'h0601);
    repeat (3) @(posedge clk);
    q <= 8'h00;
    #1 chk(trig, 1'b1);
    wr_reg(8'h06, 16'h0700);
    ticks(15);
    repeat (2) @(posedge clk);
    #1 chk(cst, 1'b0);
    ticks(1);
    repeat (2) @(posedge clk);
    ph <= 1'b1;
    #1 chk(cst, 1'b1);
    chk(ce, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(cst, 1'b0);
    wr_reg(8'h07, 16'hffff);
    rd_reg(8'h07, 16'h0000);
    rd_reg(8'h06, 16'h0700);
    wr_reg(8'h06, 16'h0600);
    repeat (2) @(posedge clk);
    #1 chk(ce, 1'b0);
    $display("config test done");
  endtask : t_cfg
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_gain();
    t_cfg();
    results();
  end
endmodule : pgc_regs_tb
